// [rtl/pdc_cfg.svh]
// Register offsets, field positions, reset values and timing for power-down
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// Register byte addresses
`define PDC_ADDR_CTRL 8'h00
`define PDC_ADDR_STAT 8'h04

// Control register fields
`define PDC_CTRL_SBY_BIT 7
`define PDC_CTRL_MSTP_LSB 0
`define PDC_CTRL_MSTP_W 5
`define PDC_CTRL_RESET 8'h00

// Status register fields
`define PDC_STAT_STATE_LSB 0
`define PDC_STAT_MANUAL_BIT 2
`define PDC_STAT_OSC_BIT 3
`define PDC_STAT_PEND_RST_BIT 4
`define PDC_STAT_PEND_NMI_BIT 5

// Module-stop bit positions
`define PDC_MSTP_MULTIPLIER_UNIT 4
`define PDC_MSTP_DIVIDER_UNIT 3
`define PDC_MSTP_TIMER 2
`define PDC_MSTP_SERIAL 1
`define PDC_MSTP_DMA 0

// Modules whose registers are initialized by module standby
`define PDC_REG_INIT_MASK 5'h06

// Oscillator stabilization, microseconds, and clock rate in MHz
`define PDC_OSC_STAB_US 1000
`define PDC_CLK_MHZ 40
`define PDC_OSC_STAB_CYCLES (`PDC_OSC_STAB_US * `PDC_CLK_MHZ)

`endif

// [rtl/pdc_pkg.sv]
// Types shared by the power-down controller modules
package pdc_pkg;

    typedef enum logic [1:0] {
        PDC_RUN = 2'b00,
        PDC_SLEEP = 2'b01,
        PDC_STANDBY = 2'b10,
        PDC_OSC_WAIT = 2'b11
    } pdc_state_e;

    typedef struct packed {
        pdc_state_e state;
        logic standby_select;
        logic [4:0] mstp;
        logic [31:0] rdata;
        logic cpu_halt;
        logic osc_en;
        logic io_standby;
        logic periph_init;
        logic exc_reset;
        logic exc_wake;
        logic exc_nmi;
        logic manual_rst;
        logic bus_pin_init;
        logic rst_prev;
        logic pend_reset;
        logic pend_manual;
        logic pend_nmi;
        logic osc_start;
    } pdc_top_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } pdc_osc_s;

    typedef struct packed {
        logic clk_en;
        logic stop_prev;
        logic pin_reset;
        logic reg_init;
        logic me_clear;
    } pdc_gate_s;

endpackage

// [rtl/pdc_osc_timer.sv]
// Oscillator stabilization wait counter
`timescale 1ns/1ps
module pdc_osc_timer #(
    parameter int unsigned STAB_CYCLES = 40000
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic start,
    output logic busy,
    output logic done
);
    pdc_pkg::pdc_osc_s st_reg;
    pdc_pkg::pdc_osc_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start) begin
            st_next.busy = 1'b1;
            st_next.cnt = 32'h0000_0000;
        end else if (st_reg.busy) begin
            // Done fires once the full count has elapsed, never early
            if (st_reg.cnt >= STAB_CYCLES - 1) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;
endmodule

// [rtl/pdc_clk_gate.sv]
// Per-peripheral clock enable with module standby initialization
`timescale 1ns/1ps
module pdc_clk_gate #(
    parameter bit INIT_REGS = 1'b1,
    parameter bit CLEAR_ME = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic stop,
    input wire logic force_init,
    output logic clk_en,
    output logic pin_reset,
    output logic reg_init,
    output logic me_clear
);
    pdc_pkg::pdc_gate_s st_reg;
    pdc_pkg::pdc_gate_s st_next;
    logic enter;

    always_comb begin
        st_next = st_reg;
        enter = (stop && !st_reg.stop_prev) || force_init;
        st_next.stop_prev = stop;
        st_next.clk_en = !stop;
        st_next.pin_reset = enter;
        st_next.reg_init = enter && INIT_REGS;
        st_next.me_clear = enter && CLEAR_ME;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_reg <= '{clk_en: 1'b1, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign clk_en = st_reg.clk_en;
    assign pin_reset = st_reg.pin_reset;
    assign reg_init = st_reg.reg_init;
    assign me_clear = st_reg.me_clear;
endmodule

// [rtl/pdc_top.sv]
// Power-down controller: sleep, software standby and module standby
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "pdc_cfg.svh"

// Notes on behaviour
// - Sleep with select 0 halts CPU only
// - Sleep ends on reset, interrupt, DMA error
// - Sleep with select 1 enters standby
// - Standby stops CPU, peripherals, oscillator
// - Standby keeps CPU registers and cache
// - Only reset or NMI ends standby
// - NMI wakes after oscillator stabilization wait
// - Reset in standby waits for stabilization
// - NMI high means power-on, low manual
// - Standby halts, initializes peripherals; pins held
// - Five stop bits gate peripheral clocks
// - Module standby resets pins; registers of serial, timer only
// - DMA standby clears DMA master enable
// - Writing stop bit 0 restores clock
// - Stopped modules keep interrupt vectors
module pdc_top #(
    parameter int unsigned OSC_STAB_CYCLES = `PDC_OSC_STAB_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sleep_exec,
    input wire logic irq_any,
    input wire logic dma_addr_err,
    input wire logic nmi_pin,
    input wire logic reset_pin_n,
    output logic cpu_halt,
    output logic cpu_state_hold,
    output logic osc_en,
    output logic io_standby,
    output logic periph_init,
    output logic exc_reset,
    output logic exc_wake,
    output logic exc_nmi,
    output logic manual_rst,
    output logic bus_pin_init,
    output logic [4:0] periph_clk_en,
    output logic [4:0] periph_pin_reset,
    output logic [4:0] periph_reg_init,
    output logic [4:0] vector_keep,
    output logic dma_me_clear
);
    localparam logic [4:0] REG_INIT_MASK = `PDC_REG_INIT_MASK;

    pdc_pkg::pdc_top_s st_reg;
    pdc_pkg::pdc_top_s st_next;

    logic osc_busy;
    logic osc_done;
    logic reset_edge;
    logic standby_entry;
    logic [4:0] gate_stop;
    logic [4:0] gate_me;

    pdc_osc_timer #(
        .STAB_CYCLES(OSC_STAB_CYCLES)
    ) u_osc (
        .mclk(mclk),
        .rstn(rstn),
        .start(st_reg.osc_start),
        .busy(osc_busy),
        .done(osc_done)
    );

    // Standby stops every peripheral clock regardless of its stop bit
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            gate_stop[i] = st_reg.mstp[i] ||
                (st_reg.state != pdc_pkg::PDC_RUN &&
                 st_reg.state != pdc_pkg::PDC_SLEEP);
        end
    end

    assign standby_entry = st_reg.periph_init;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : gen_gate
            pdc_clk_gate #(
                .INIT_REGS(REG_INIT_MASK[g]),
                .CLEAR_ME(g == `PDC_MSTP_DMA)
            ) u_gate (
                .mclk(mclk),
                .rstn(rstn),
                .stop(gate_stop[g]),
                .force_init(standby_entry),
                .clk_en(periph_clk_en[g]),
                .pin_reset(periph_pin_reset[g]),
                .reg_init(periph_reg_init[g]),
                .me_clear(gate_me[g])
            );
        end
    endgenerate

    // Only the DMA slot carries a master enable clear
    assign dma_me_clear = gate_me[`PDC_MSTP_DMA];

    // Reset pin taken on its falling edge so a held pin acts once
    assign reset_edge = st_reg.rst_prev && !reset_pin_n;

    always_comb begin
        st_next = st_reg;
        st_next.rst_prev = reset_pin_n;
        st_next.exc_reset = 1'b0;
        st_next.exc_wake = 1'b0;
        st_next.exc_nmi = 1'b0;
        st_next.bus_pin_init = 1'b0;
        st_next.periph_init = 1'b0;
        st_next.osc_start = 1'b0;
        st_next.rdata = 32'h0000_0000;

        // Register writes; a reset below overrides them
        if (reg_wr && reg_addr == `PDC_ADDR_CTRL) begin
            st_next.standby_select = reg_wdata[`PDC_CTRL_SBY_BIT];
            st_next.mstp = reg_wdata[`PDC_CTRL_MSTP_LSB +:
                `PDC_CTRL_MSTP_W];
        end

        // Read data stands one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `PDC_ADDR_CTRL: begin
                    st_next.rdata[`PDC_CTRL_SBY_BIT] = st_reg.standby_select;
                    st_next.rdata[`PDC_CTRL_MSTP_LSB +:
                        `PDC_CTRL_MSTP_W] = st_reg.mstp;
                end
                `PDC_ADDR_STAT: begin
                    st_next.rdata[`PDC_STAT_STATE_LSB +: 2] = st_reg.state;
                    st_next.rdata[`PDC_STAT_MANUAL_BIT] = st_reg.manual_rst;
                    st_next.rdata[`PDC_STAT_OSC_BIT] = st_reg.osc_en;
                    st_next.rdata[`PDC_STAT_PEND_RST_BIT] =
                        st_reg.pend_reset;
                    st_next.rdata[`PDC_STAT_PEND_NMI_BIT] = st_reg.pend_nmi;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        case (st_reg.state)
            pdc_pkg::PDC_RUN: begin
                st_next.cpu_halt = 1'b0;
                if (reset_edge) begin
                    st_next.exc_reset = 1'b1;
                end else if (sleep_exec) begin
                    // Old select value, not a write in this cycle
                    if (st_reg.standby_select) begin
                        st_next.state = pdc_pkg::PDC_STANDBY;
                        st_next.cpu_halt = 1'b1;
                        st_next.osc_en = 1'b0;
                        st_next.io_standby = 1'b1;
                        st_next.periph_init = 1'b1;
                    end else begin
                        // Peripheral clocks keep running
                        st_next.state = pdc_pkg::PDC_SLEEP;
                        st_next.cpu_halt = 1'b1;
                    end
                end
            end
            pdc_pkg::PDC_SLEEP: begin
                if (reset_edge) begin
                    st_next.state = pdc_pkg::PDC_RUN;
                    st_next.cpu_halt = 1'b0;
                    st_next.exc_reset = 1'b1;
                end else if (irq_any || dma_addr_err || nmi_pin) begin
                    st_next.state = pdc_pkg::PDC_RUN;
                    st_next.cpu_halt = 1'b0;
                    st_next.exc_wake = 1'b1;
                    st_next.exc_nmi = nmi_pin;
                end
            end
            pdc_pkg::PDC_STANDBY: begin
                // Maskable interrupts and DMA errors are ignored here
                if (reset_edge || nmi_pin) begin
                    st_next.state = pdc_pkg::PDC_OSC_WAIT;
                    st_next.osc_en = 1'b1;
                    st_next.osc_start = 1'b1;
                    st_next.pend_reset = reset_edge;
                    st_next.pend_nmi = !reset_edge;
                end
            end
            pdc_pkg::PDC_OSC_WAIT: begin
                if (reset_edge) begin
                    st_next.pend_reset = 1'b1;
                    st_next.pend_nmi = 1'b0;
                end
                if (osc_done) begin
                    st_next.state = pdc_pkg::PDC_RUN;
                    st_next.cpu_halt = 1'b0;
                    st_next.io_standby = 1'b0;
                    st_next.pend_reset = 1'b0;
                    st_next.pend_nmi = 1'b0;
                    if (st_reg.pend_reset || reset_edge) begin
                        st_next.exc_reset = 1'b1;
                        st_next.manual_rst = st_reg.pend_manual;
                        st_next.bus_pin_init = !st_reg.pend_manual;
                    end else begin
                        st_next.exc_wake = 1'b1;
                        st_next.exc_nmi = 1'b1;
                    end
                end
            end
            default: begin
                st_next.state = pdc_pkg::PDC_RUN;
            end
        endcase

        // Register clear and pend_manual act in every state; manual_rst and bus_pin_init only from run or sleep
        if (reset_edge) begin
            st_next.standby_select = 1'b0;
            st_next.mstp = 5'h00;
            st_next.pend_manual = !nmi_pin;
            if (st_reg.state == pdc_pkg::PDC_RUN ||
                st_reg.state == pdc_pkg::PDC_SLEEP) begin
                st_next.manual_rst = !nmi_pin;
                st_next.bus_pin_init = nmi_pin;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_reg <= '{state: pdc_pkg::PDC_RUN, osc_en: 1'b1,
                rst_prev: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign cpu_halt = st_reg.cpu_halt;
    // Register and cache contents held whenever the CPU is halted
    assign cpu_state_hold = st_reg.cpu_halt;
    assign osc_en = st_reg.osc_en;
    assign io_standby = st_reg.io_standby;
    assign periph_init = st_reg.periph_init;
    assign exc_reset = st_reg.exc_reset;
    assign exc_wake = st_reg.exc_wake;
    assign exc_nmi = st_reg.exc_nmi;
    assign manual_rst = st_reg.manual_rst;
    assign bus_pin_init = st_reg.bus_pin_init;
    // Vector settings survive module standby; never part of reg init
    assign vector_keep = st_reg.mstp;
endmodule

// [test/pdc_top_props.sv]
// Port checker for the power-down controller
`timescale 1ns/1ps
module pdc_top_props #(
    parameter int unsigned OSC_STAB_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sleep_exec,
    input wire logic irq_any,
    input wire logic dma_addr_err,
    input wire logic nmi_pin,
    input wire logic reset_pin_n,
    input wire logic cpu_halt,
    input wire logic osc_en,
    input wire logic io_standby,
    input wire logic exc_wake,
    input wire logic exc_nmi,
    input wire logic [4:0] periph_clk_en,
    input wire logic [4:0] periph_pin_reset,
    input wire logic [4:0] periph_reg_init,
    input wire logic [4:0] vector_keep,
    input wire logic dma_me_clear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [31:0] wcnt_reg;
    logic [31:0] wcnt_next;
    sequence held_s;
        cpu_halt && io_standby && osc_en;
    endsequence
    sequence woke_s;
        !cpu_halt && exc_wake;
    endsequence
    // Settling cycles seen before wake, since wake may not come early
    always_comb begin
        wcnt_next = 32'h0000_0000;
        if (osc_en && io_standby) begin
            wcnt_next = wcnt_reg + 32'h0000_0001;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wcnt_reg <= 32'h0000_0000;
        end else begin
            wcnt_reg <= wcnt_next;
        end
    end
    sleep_enter_a: assert property (
        sleep_exec && !cpu_halt && reset_pin_n |=> cpu_halt)
        else $error("sleep instruction did not halt the cpu");
    sleep_wake_a: assert property (
        cpu_halt && osc_en && !io_standby && reset_pin_n &&
        (irq_any || dma_addr_err)
        |=> woke_s) else $error("sleep mode not left on wake source");
    stby_halt_a: assert property (
        !osc_en |-> cpu_halt && io_standby)
        else $error("standby without cpu halt or pin hold");
    stby_clk_a: assert property (
        !osc_en && !$past(osc_en) |-> periph_clk_en == 5'h00)
        else $error("peripheral clock runs in standby");
    stby_ignore_a: assert property (
        !osc_en && !nmi_pin && reset_pin_n |=> !osc_en)
        else $error("standby ended without reset or nmi");
    osc_stab_a: assert property (
        $fell(io_standby) |-> wcnt_reg >= OSC_STAB_CYCLES)
        else $error("wake before oscillator settled");
    wait_end_a: assert property (
        $rose(osc_en) |-> held_s [*2] ##[1:60] !io_standby)
        else $error("oscillator wait did not end in time");
    nmi_pair_a: assert property (exc_nmi |-> exc_wake)
        else $error("nmi exception without wake");
    keep_gate_a: assert property (
        ((vector_keep & $past(vector_keep)) & periph_clk_en) == 5'h00)
        else $error("stopped module still clocked");
    reg_init_a: assert property (
        (periph_reg_init & 5'h19) == 5'h00)
        else $error("register init on a module that keeps registers");
    dma_me_a: assert property (
        dma_me_clear |-> periph_pin_reset[0] && !periph_clk_en[0])
        else $error("dma enable clear outside dma standby");
    restart_a: assert property (
        $fell(vector_keep[1]) && osc_en && !io_standby
        |-> ##[0:2] periph_clk_en[1])
        else $error("clock not restored after stop bit cleared");
endmodule

// [test/pdc_top_tb.sv]
// Self-checking bench for the power-down controller
`timescale 1ns/1ps
module pdc_top_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_exec = 1'b0;
    logic irq_any = 1'b0;
    logic dma_addr_err = 1'b0;
    logic nmi_pin = 1'b0;
    logic reset_pin_n = 1'b1;
    logic [31:0] reg_rdata;
    logic cpu_halt, cpu_state_hold, osc_en, io_standby, periph_init;
    logic exc_reset, exc_wake, exc_nmi, manual_rst, bus_pin_init;
    logic [4:0] periph_clk_en, periph_pin_reset, periph_reg_init, vector_keep;
    logic dma_me_clear, seen;
    logic [31:0] xs = 32'h0000_0024;
    logic [31:0] rd_val;
    int bad_count = 0;
    int samples_checked = 0;
    int m_stop;
    int prev_stop = 0;
    int r_stop;
    int n;

    always #12.5 mclk = ~mclk;

    // Short settling count keeps the run brief
    pdc_top #(.OSC_STAB_CYCLES(8)) pdc_top_inst (.mclk, .rstn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .irq_any,
        .dma_addr_err, .nmi_pin, .reset_pin_n, .cpu_halt, .cpu_state_hold,
        .osc_en, .io_standby, .periph_init, .exc_reset, .exc_wake, .exc_nmi,
        .manual_rst, .bus_pin_init, .periph_clk_en, .periph_pin_reset,
        .periph_reg_init, .vector_keep, .dma_me_clear);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d of %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic slp();
        @(posedge mclk);
        sleep_exec <= 1'b1;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        #1;
    endtask

    task automatic wake_sleep(input logic use_dma);
        @(posedge mclk);
        irq_any <= !use_dma;
        dma_addr_err <= use_dma;
        @(posedge mclk);
        irq_any <= 1'b0;
        dma_addr_err <= 1'b0;
        #1;
        chk({cpu_halt, exc_wake}, 32'h0000_0001);
    endtask

    // Bounded wait for an exception request, noting bus and pin init
    task automatic wait_exc(input logic want_rst);
        seen = 1'b0;
        for (n = 0; n < 60; n++) begin
            @(posedge mclk);
            #1;
            seen = seen | bus_pin_init;
            if (want_rst ? exc_reset : exc_wake) break;
        end
    endtask

    initial begin
        #(25 * 4000);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        chk({cpu_halt, osc_en, periph_clk_en}, 32'h0000_003F);
        for (int i = 0; i < 8; i++) begin
            xs = xs ^ (xs << 13);
            xs = xs ^ (xs >> 17);
            xs = xs ^ (xs << 5);
            m_stop = (i == 7) ? 31 : int'(xs[4:0]);
            wr(8'h00, 32'(m_stop));
            @(posedge mclk);
            #1;
            // Only newly stopped modules see the init pulses
            r_stop = m_stop & ~prev_stop;
            chk({periph_pin_reset, periph_reg_init, dma_me_clear},
                32'({r_stop[4:0], r_stop[4:0] & 5'h06, r_stop[0]}));
            prev_stop = m_stop;
            @(posedge mclk);
            #1;
            chk(periph_clk_en, 32'(~m_stop & 31));
            chk(vector_keep, 32'(m_stop));
            rd(8'h00);
            chk(rd_val, 32'(m_stop));
        end
        wr(8'h00, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        #1;
        chk(periph_clk_en, 32'h0000_001F);
        rd(8'h08);
        chk(rd_val, 32'h0000_0000);
        // Select written in the sleep cycle must not count yet
        @(posedge mclk);
        sleep_exec <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h0000_0080;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        chk({cpu_halt, osc_en, io_standby, periph_clk_en},
            32'h0000_00DF);
        wake_sleep(1'b0);
        wr(8'h00, 32'h0000_0000);
        slp();
        chk({cpu_halt, osc_en, io_standby}, 32'h0000_0006);
        rd(8'h04);
        chk(rd_val, 32'h0000_0009);
        wake_sleep(1'b1);
        wr(8'h00, 32'h0000_0080);
        slp();
        chk({cpu_halt, cpu_state_hold, osc_en, io_standby, periph_init},
            32'h0000_001B);
        @(posedge mclk);
        irq_any <= 1'b1;
        dma_addr_err <= 1'b1;
        #1;
        chk(periph_clk_en, 32'h0000_0000);
        chk({periph_pin_reset, periph_reg_init, dma_me_clear},
            32'h0000_07CD);
        repeat (3) @(posedge mclk);
        irq_any <= 1'b0;
        dma_addr_err <= 1'b0;
        #1;
        chk({cpu_halt, osc_en}, 32'h0000_0002);
        rd(8'h04);
        chk(rd_val, 32'h0000_0002);
        @(posedge mclk);
        nmi_pin <= 1'b1;
        @(posedge mclk);
        nmi_pin <= 1'b0;
        wait_exc(1'b0);
        chk({exc_nmi, cpu_halt, n >= 8, n < 60}, 32'h0000_000B);
        slp();
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        @(posedge mclk);
        reset_pin_n <= 1'b1;
        wait_exc(1'b1);
        chk({seen, manual_rst, n >= 8, n < 60}, 32'h0000_0007);
        // Reset cleared the select bit; power-on reset from standby
        wr(8'h00, 32'h0000_0080);
        slp();
        @(posedge mclk);
        nmi_pin <= 1'b1;
        reset_pin_n <= 1'b0;
        @(posedge mclk);
        reset_pin_n <= 1'b1;
        wait_exc(1'b1);
        @(posedge mclk);
        nmi_pin <= 1'b0;
        seen = seen | bus_pin_init;
        chk({seen, manual_rst, n < 60}, 32'h0000_0005);
        end_of_test();
    end
endmodule

bind pdc_top pdc_top_props #(.OSC_STAB_CYCLES(OSC_STAB_CYCLES))
    pdc_top_props_inst (
    .mclk, .rstn, .sleep_exec, .irq_any, .dma_addr_err, .nmi_pin,
    .reset_pin_n, .cpu_halt, .osc_en, .io_standby, .exc_wake, .exc_nmi,
    .periph_clk_en, .periph_pin_reset, .periph_reg_init, .vector_keep,
    .dma_me_clear);
